// ===== design/gof_frame_formatter.sv
// gyro output frame formatter: two-wire record and serial frame
`timescale 1ns/1ps
module gof_frame_formatter #(
   parameter int INT_LOW = gof_pkg::INT_LOW_CYCLES
) (
   input  wire logic        ref_clk,
   input  wire logic        rst,
   input  wire logic        ce,
   input  wire logic        sample_valid,
   input  wire logic [15:0] angle_in,
   input  wire logic [15:0] rate_in,
   input  wire logic        link_clk,
   input  wire logic        strap_int_in,
   output logic             int_out,
   output logic             int_oe,
   input  wire logic        scl_rx_in,
   input  wire logic        sda_tx_in,
   output logic             sda_tx_out,
   output logic             sda_tx_oe
);
   function automatic logic [15:0] wrap_angle(input logic [15:0] a);
      logic signed [15:0] s;
      s = a;
      if (s > gof_pkg::ANGLE_HALF)
         wrap_angle = 16'(s - gof_pkg::ANGLE_FULL);
      else if (s < -gof_pkg::ANGLE_HALF)
         wrap_angle = 16'(s + gof_pkg::ANGLE_FULL);
      else
         wrap_angle = a;
   endfunction

   function automatic logic [7:0] rec_byte(input logic [2:0] i, input logic [15:0] a, input logic [15:0] r);
      logic [15:0] c;
      c = 16'(a + r);
      case (i)
         3'h0:    rec_byte = a[15:8];
         3'h1:    rec_byte = a[7:0];
         3'h2:    rec_byte = r[15:8];
         3'h3:    rec_byte = r[7:0];
         3'h4:    rec_byte = c[15:8];
         3'h5:    rec_byte = c[7:0];
         default: rec_byte = gof_pkg::I2C_PAD;
      endcase
   endfunction

   function automatic logic [7:0] sum_bytes(input logic [15:0] a, input logic [15:0] r, input logic [15:0] c);
      sum_bytes = 8'(gof_pkg::HEAD_BYTE + gof_pkg::HEAD_BYTE + r[7:0] + r[15:8] + a[7:0] + a[15:8]
                     + c[7:0] + c[15:8] + gof_pkg::STATUS_WORD[7:0] + gof_pkg::STATUS_WORD[15:8]);
   endfunction

   function automatic logic [7:0] frame_byte(input logic [3:0] i, input logic [15:0] a, input logic [15:0] r);
      logic [15:0] c;
      c = 16'(gof_pkg::HEAD_WORD + r + a);
      case (i)
         4'(gof_pkg::OFS_HEAD0):      frame_byte = gof_pkg::HEAD_BYTE;
         4'(gof_pkg::OFS_HEAD1):      frame_byte = gof_pkg::HEAD_BYTE;
         4'(gof_pkg::OFS_RATE):       frame_byte = r[7:0];
         4'(gof_pkg::OFS_RATE + 1):   frame_byte = r[15:8];
         4'(gof_pkg::OFS_ANGLE):      frame_byte = a[7:0];
         4'(gof_pkg::OFS_ANGLE + 1):  frame_byte = a[15:8];
         4'(gof_pkg::OFS_CHK):        frame_byte = c[7:0];
         4'(gof_pkg::OFS_CHK + 1):    frame_byte = c[15:8];
         4'(gof_pkg::OFS_STATUS):     frame_byte = gof_pkg::STATUS_WORD[7:0];
         4'(gof_pkg::OFS_STATUS + 1): frame_byte = gof_pkg::STATUS_WORD[15:8];
         4'(gof_pkg::OFS_SUM):        frame_byte = sum_bytes(a, r, c);
         4'(gof_pkg::OFS_END0):       frame_byte = gof_pkg::END0_BYTE;
         default:                     frame_byte = gof_pkg::END1_BYTE;
      endcase
   endfunction

   ////////////////////////////////////////////////////////////////////////////////////////////
   // reference domain: strap, snapshot, data-ready pin
   logic        strap_m, strap_s;
   logic        strap_done, mode_uart;
   logic        xfer_busy, req_t, ack_t;
   logic [15:0] snap_angle, snap_rate;
   logic        ack_m, ack_s, ack_d;
   logic [7:0]  int_cnt;
   // stale toggles left over from a reset are dropped
   wire         ack_evt  = (ack_s ^ ack_d) && xfer_busy;
   wire         take_new = ce && sample_valid && !xfer_busy;

   always_ff @(posedge ref_clk)
   begin
      strap_m <= strap_int_in;
      strap_s <= strap_m;
      ack_m   <= ack_t;
      ack_s   <= ack_m;
   end

   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         strap_done <= 1'b0;
         mode_uart  <= 1'b0;
         int_oe     <= 1'b0;
      end
      else if (ce)
      begin
         if (!strap_done)
            mode_uart <= ~strap_s;
         strap_done <= 1'b1;
         int_oe     <= strap_done;
      end
   end

   // snapshot held until the link takes it
   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         xfer_busy  <= 1'b0;
         req_t      <= 1'b0;
         ack_d      <= 1'b0;
         snap_angle <= 16'h0000;
         snap_rate  <= 16'h0000;
      end
      else if (ce)
      begin
         ack_d <= ack_s;
         if (take_new)
         begin
            snap_angle <= wrap_angle(angle_in);
            snap_rate  <= rate_in;
            req_t      <= ~req_t;
            xfer_busy  <= 1'b1;
         end
         else if (ack_evt)
            xfer_busy <= 1'b0;
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         int_out <= 1'b1;
         int_cnt <= 8'h00;
      end
      else if (ce)
      begin
         if (ack_evt && strap_done)
         begin
            int_out <= 1'b0;
            int_cnt <= 8'(INT_LOW);
         end
         else if (int_cnt != 8'h00)
         begin
            int_cnt <= int_cnt - 8'h01;
            int_out <= (int_cnt == 8'h01);
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////////
   // link domain: synchronisers and record copy
   logic        lrst_m, lrst;
   logic        lce_m, lce;
   logic        mode_m, lmode;
   logic        req_m, req_s;
   logic        scl_m, scl_s, scl_d, sda_m, sda_s, sda_d;
   logic [15:0] rec_angle, rec_rate;
   logic        fbusy, tx_go, tx_busy, tx_line;
   logic [3:0]  fidx;
   logic [7:0]  tx_byte;
   gof_pkg::gof_i2c_state_type ist;
   wire         i2c_active = (ist != gof_pkg::GOF_I_IDLE);
   wire         link_cap   = lce && (req_s != ack_t) && !i2c_active && !fbusy && !tx_busy;
   wire         scl_rise   = scl_s && !scl_d;
   wire         scl_fall   = !scl_s && scl_d;
   wire         start_det  = scl_s && scl_d && sda_d && !sda_s;
   wire         stop_det   = scl_s && scl_d && !sda_d && sda_s;

   always_ff @(posedge link_clk)
   begin
      lrst_m <= rst;
      lrst   <= lrst_m;
      lce_m  <= ce;
      lce    <= lce_m;
      mode_m <= mode_uart;
      lmode  <= mode_m;
      req_m  <= req_t;
      req_s  <= req_m;
      scl_m  <= scl_rx_in;
      scl_s  <= scl_m;
      sda_m  <= sda_tx_in;
      sda_s  <= sda_m;
   end

   always_ff @(posedge link_clk)
   begin
      if (lrst)
      begin
         ack_t     <= 1'b0;
         rec_angle <= 16'h0000;
         rec_rate  <= 16'h0000;
         scl_d     <= 1'b1;
         sda_d     <= 1'b1;
      end
      else if (lce)
      begin
         scl_d <= scl_s;
         sda_d <= sda_s;
         if (link_cap)
         begin
            rec_angle <= snap_angle;
            rec_rate  <= snap_rate;
            ack_t     <= ~ack_t;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////////
   // serial frame sequencer; rx is not used, the link is send-only
   // thirteen bytes per new sample
   always_ff @(posedge link_clk)
   begin
      if (lrst)
      begin
         fbusy   <= 1'b0;
         fidx    <= 4'h0;
         tx_go   <= 1'b0;
         tx_byte <= 8'h00;
      end
      else if (lce)
      begin
         tx_go <= 1'b0;
         if (link_cap && lmode)
         begin
            fbusy <= 1'b1;
            fidx  <= 4'h0;
         end
         else if (fbusy && !tx_busy && !tx_go)
         begin
            tx_go   <= 1'b1;
            tx_byte <= frame_byte(fidx, rec_angle, rec_rate);
            fidx    <= fidx + 4'h1;
            fbusy   <= (fidx != 4'(gof_pkg::FRAME_LEN - 1));
         end
      end
   end

   gof_uart_tx #(
      .DIV (gof_pkg::BAUD_DIV)
   ) u_tx (
      .clk   (link_clk),
      .rst   (lrst),
      .ce    (lce),
      .start (tx_go),
      .data  (tx_byte),
      .tx    (tx_line),
      .busy  (tx_busy)
   );

   ////////////////////////////////////////////////////////////////////////////////////////////
   // two-wire target, read-only record; written bytes are acked and dropped
   logic [3:0] bcnt;
   logic [7:0] in_sh, out_sh;
   logic [2:0] ridx;
   logic       rd_dir, nack, i2c_oe;
   wire  [7:0] next_out = rec_byte(ridx, rec_angle, rec_rate);
   wire        addr_hit = (in_sh[7:1] == gof_pkg::I2C_ADDR);

   always_ff @(posedge link_clk)
   begin
      if (lrst)
      begin
         ist    <= gof_pkg::GOF_I_IDLE;
         bcnt   <= 4'h0;
         in_sh  <= 8'h00;
         out_sh <= 8'h00;
         ridx   <= 3'h0;
         rd_dir <= 1'b0;
         nack   <= 1'b0;
         i2c_oe <= 1'b0;
      end
      else if (lce && !lmode)
      begin
         if (start_det)
         begin
            ist    <= gof_pkg::GOF_I_ADDR;
            bcnt   <= 4'h0;
            i2c_oe <= 1'b0;
         end
         else if (stop_det)
         begin
            ist    <= gof_pkg::GOF_I_IDLE;
            i2c_oe <= 1'b0;
         end
         else
            case (ist)
               gof_pkg::GOF_I_ADDR, gof_pkg::GOF_I_WR:
                  if (scl_rise)
                  begin
                     in_sh <= {in_sh[6:0], sda_s};
                     bcnt  <= bcnt + 4'h1;
                  end
                  else if (scl_fall && bcnt == 4'h8)
                  begin
                     if (ist == gof_pkg::GOF_I_WR || addr_hit)
                     begin
                        i2c_oe <= 1'b1;
                        ist    <= (ist == gof_pkg::GOF_I_WR) ? gof_pkg::GOF_I_WACK : gof_pkg::GOF_I_AACK;
                     end
                     else
                        ist <= gof_pkg::GOF_I_IDLE;
                     if (ist == gof_pkg::GOF_I_ADDR)
                        rd_dir <= in_sh[0];
                     ridx <= 3'h0;
                  end
               gof_pkg::GOF_I_AACK, gof_pkg::GOF_I_WACK:
                  if (scl_fall)
                  begin
                     bcnt <= 4'h0;
                     if (ist == gof_pkg::GOF_I_AACK && rd_dir)
                     begin
                        out_sh <= next_out;
                        i2c_oe <= ~next_out[7];
                        ist    <= gof_pkg::GOF_I_RD;
                     end
                     else
                     begin
                        i2c_oe <= 1'b0;
                        ist    <= gof_pkg::GOF_I_WR;
                     end
                  end
               gof_pkg::GOF_I_RD:
                  if (scl_rise)
                     bcnt <= bcnt + 4'h1;
                  else if (scl_fall && bcnt == 4'h8)
                  begin
                     i2c_oe <= 1'b0;
                     ist    <= gof_pkg::GOF_I_RACK;
                     if (ridx != 3'h7)
                        ridx <= 3'(ridx + 3'h1);
                  end
                  else if (scl_fall)
                  begin
                     out_sh <= {out_sh[6:0], 1'b0};
                     i2c_oe <= ~out_sh[6];
                  end
               gof_pkg::GOF_I_RACK:
                  if (scl_rise)
                     nack <= sda_s;
                  else if (scl_fall && nack)
                     ist <= gof_pkg::GOF_I_IDLE;
                  else if (scl_fall)
                  begin
                     // next byte straight after the master ack
                     out_sh <= next_out;
                     i2c_oe <= ~next_out[7];
                     ist    <= gof_pkg::GOF_I_RD;
                     bcnt   <= 4'h0;
                  end
               default:
                  ist <= gof_pkg::GOF_I_IDLE;
            endcase
      end
   end

   // shared data pin: tx in serial mode, open-drain sda otherwise
   always_ff @(posedge link_clk)
   begin
      if (lrst)
      begin
         sda_tx_out <= 1'b1;
         sda_tx_oe  <= 1'b0;
      end
      else if (lce)
      begin
         sda_tx_out <= lmode ? tx_line : 1'b0;
         sda_tx_oe  <= lmode ? 1'b1 : i2c_oe;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////////
   property p_addr_ack;
      @(posedge link_clk) disable iff (lrst)
      (lce && !lmode && !start_det && !stop_det && ist == gof_pkg::GOF_I_ADDR && scl_fall && bcnt == 4'h8
       && addr_hit) |=> (ist == gof_pkg::GOF_I_AACK && i2c_oe) ##1 sda_tx_oe;
   endproperty
   a_addr_ack: assert property (p_addr_ack) else $error("own address not acknowledged");

   property p_head;
      @(posedge link_clk) disable iff (lrst)
      (lce && fbusy && !tx_busy && !tx_go && fidx < 4'h2) |=> (tx_go && tx_byte == gof_pkg::HEAD_BYTE);
   endproperty
   a_head: assert property (p_head) else $error("header byte wrong");

   property p_end;
      @(posedge link_clk) disable iff (lrst)
      (lce && fbusy && !tx_busy && !tx_go && fidx == 4'hc) |=> (tx_byte == gof_pkg::END1_BYTE && !fbusy);
   endproperty
   a_end: assert property (p_end) else $error("frame did not end with terminator");

   property p_rate_lsb;
      @(posedge link_clk) disable iff (lrst)
      (lce && fbusy && !tx_busy && !tx_go && fidx == 4'h2) |=> (tx_byte == rec_rate[7:0]);
   endproperty
   a_rate_lsb: assert property (p_rate_lsb) else $error("rate low byte misplaced");

   property p_sum;
      @(posedge link_clk) disable iff (lrst)
      (lce && fbusy && !tx_busy && !tx_go && fidx == 4'ha)
      |=> (tx_byte == sum_bytes(rec_angle, rec_rate, 16'(gof_pkg::HEAD_WORD + rec_rate + rec_angle)));
   endproperty
   a_sum: assert property (p_sum) else $error("frame byte sum wrong");

   property p_rec_msb;
      @(posedge link_clk) disable iff (lrst)
      (lce && !lmode && !start_det && !stop_det && ist == gof_pkg::GOF_I_RACK && scl_fall && !nack
       && ridx == 3'h4) |=> (out_sh == 8'((16'(rec_angle + rec_rate)) >> 8));
   endproperty
   a_rec_msb: assert property (p_rec_msb) else $error("check word high byte wrong");

   property p_hold;
      @(posedge link_clk) disable iff (lrst)
      (i2c_active || fbusy) |=> ($stable(rec_angle) && $stable(rec_rate));
   endproperty
   a_hold: assert property (p_hold) else $error("record changed during transfer");

   property p_int_fall;
      @(posedge ref_clk) disable iff (rst)
      (ce && ack_evt && strap_done) |=> !int_out ##1 (!int_out || !ce);
   endproperty
   a_int_fall: assert property (p_int_fall) else $error("data-ready did not fall");

   property p_strap;
      @(posedge ref_clk) disable iff (rst)
      (strap_done && $past(strap_done)) |-> ($stable(mode_uart) && int_oe == $past(strap_done));
   endproperty
   a_strap: assert property (p_strap) else $error("mode changed after strap");
endmodule

// ===== design/gof_pkg.sv
// constants and types shared by the gyro output frame formatter
package gof_pkg;
   // clocks and link timing
   localparam int REF_CLK_HZ  = 40_000_000;
   localparam int LINK_CLK_HZ = 12_500_000;
   localparam int BAUD_RATE   = 115200;
   localparam int BAUD_DIV    = LINK_CLK_HZ / BAUD_RATE;
   localparam int UART_BITS   = 10;
   // data-ready pulse on the shared pin
   localparam int INT_LOW_NS     = 1000;
   localparam int INT_LOW_CYCLES = (INT_LOW_NS * (REF_CLK_HZ / 1_000_000) + 999) / 1000;
   // two-wire record
   localparam logic [6:0] I2C_ADDR    = 7'h6a;
   localparam int         I2C_REC_LEN = 6;
   localparam logic [7:0] I2C_PAD     = 8'h00;
   // serial frame layout
   localparam int FRAME_LEN  = 13;
   localparam int OFS_HEAD0  = 0;
   localparam int OFS_HEAD1  = 1;
   localparam int OFS_RATE   = 2;
   localparam int OFS_ANGLE  = 4;
   localparam int OFS_CHK    = 6;
   localparam int OFS_STATUS = 8;
   localparam int OFS_SUM    = 10;
   localparam int OFS_END0   = 11;
   localparam int OFS_END1   = 12;
   localparam logic [7:0]  HEAD_BYTE    = 8'hff;
   localparam logic [15:0] HEAD_WORD    = 16'hffff;
   localparam logic [7:0]  END0_BYTE    = 8'h0d;
   localparam logic [7:0]  END1_BYTE    = 8'h0a;
   localparam logic [15:0] STATUS_WORD  = 16'h0000;
   // angle wrap in hundredths of a degree
   localparam logic signed [15:0] ANGLE_HALF = 16'sh4650;
   localparam logic signed [15:0] ANGLE_FULL = 16'sh8ca0;
   // two-wire target states, gray along the usual path
   typedef enum logic [2:0] {
      GOF_I_IDLE = 3'h0,
      GOF_I_ADDR = 3'h1,
      GOF_I_AACK = 3'h3,
      GOF_I_RD   = 3'h2,
      GOF_I_RACK = 3'h6,
      GOF_I_WR   = 3'h7,
      GOF_I_WACK = 3'h5
   } gof_i2c_state_type;
endpackage

// ===== design/gof_uart_tx.sv
// 8n1 byte transmitter for the serial frame
`timescale 1ns/1ps
module gof_uart_tx #(
   parameter int DIV = gof_pkg::BAUD_DIV
) (
   input  wire logic       clk,
   input  wire logic       rst,
   input  wire logic       ce,
   input  wire logic       start,
   input  wire logic [7:0] data,
   output logic            tx,
   output logic            busy
);
   localparam int DW = $clog2(DIV + 1);
   logic [DW-1:0] baud_cnt;
   logic [3:0]    bit_cnt;
   logic [9:0]    shreg;
   wire           baud_tick = (baud_cnt == DW'(DIV - 1));
   wire           last_bit  = (bit_cnt == 4'(gof_pkg::UART_BITS - 1));

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         tx       <= 1'b1;
         busy     <= 1'b0;
         baud_cnt <= '0;
         bit_cnt  <= 4'h0;
         shreg    <= 10'h3ff;
      end
      else if (ce)
      begin
         if (!busy && start)
         begin
            busy     <= 1'b1;
            shreg    <= {1'b1, data, 1'b0};
            tx       <= 1'b0;
            baud_cnt <= '0;
            bit_cnt  <= 4'h0;
         end
         else if (busy && baud_tick)
         begin
            baud_cnt <= '0;
            if (last_bit)
            begin
               busy <= 1'b0;
               tx   <= 1'b1;
            end
            else
            begin
               bit_cnt <= bit_cnt + 4'h1;
               shreg   <= {1'b1, shreg[9:1]};
               tx      <= shreg[1];
            end
         end
         else if (busy)
            baud_cnt <= baud_cnt + DW'(1);
      end
   end

   property p_start_bit;
      @(posedge clk) disable iff (rst)
      (ce && !busy && start) |=> (!tx && busy);
   endproperty
   a_start_bit: assert property (p_start_bit) else $error("start bit not driven low");

   property p_lsb_first;
      @(posedge clk) disable iff (rst)
      (ce && busy && baud_tick && !last_bit) |=> (tx == $past(shreg[1]) && busy);
   endproperty
   a_lsb_first: assert property (p_lsb_first) else $error("data bit order wrong");
endmodule

// ===== tb/gof_host_model.sv
// host model: two-wire master and serial receiver
`timescale 1ns/1ps
module gof_host_model (
   output logic      scl,
   output logic      sda_low,
   input  wire logic sda
);
   // nominal rate, so baud error of the link shows up
   localparam real BIT_NS = 1.0e9 / 115200.0;
   initial
   begin
      scl = 1'b1;
      sda_low = 1'b0;
   end
   task automatic put_bit(input logic b);
      sda_low = !b;
      #600 scl = 1'b1;
      #1250 scl = 1'b0;
      #650;
   endtask
   task automatic get_bit(output logic b);
      sda_low = 1'b0;
      #600 scl = 1'b1;
      #625 b = sda;
      #625 scl = 1'b0;
      #650;
   endtask
   task automatic i2c_read(input logic [6:0] a, output logic ack_n, output logic [7:0] d [7]);
      logic [7:0] adr;
      adr = {a, 1'b1};
      sda_low = 1'b1;
      #1250 scl = 1'b0;
      #650;
      for (int i = 7; i >= 0; i--) put_bit(adr[i]);
      get_bit(ack_n);
      for (int k = 0; k < 7 && !ack_n; k++)
      begin
         for (int i = 7; i >= 0; i--) get_bit(d[k][i]);
         // nack on the last byte ends the read
         put_bit(k == 6);
      end
      sda_low = 1'b1;
      #600 scl = 1'b1;
      #1250 sda_low = 1'b0;
      #1250;
   endtask
   task automatic uart_rx(output logic [8:0] b);
      wait (sda === 1'b0);
      #(BIT_NS * 1.5);
      for (int i = 0; i < 9; i++)
      begin
         b[i] = sda;
         if (i < 8) #(BIT_NS);
      end
   endtask
endmodule

// ===== tb/testbench.sv
// self-checking bench for the frame formatter
`timescale 1ns/1ps
module testbench;
   localparam int INT_LOW = 2;
   logic        ref_clk;
   logic        link_clk;
   logic        rst;
   logic        ce;
   logic        strap;
   logic        sample_valid;
   logic [15:0] angle_in;
   logic [15:0] rate_in;
   logic        int_out;
   logic        int_oe;
   logic        sda_tx_out;
   logic        sda_tx_oe;
   logic        scl;
   logic        sda_low;
   logic [31:0] seed;
   int          miscompares;
   int          num_checks;
   // strap resistor (high or low) on the data-ready pin, pull-up on sda
   wire         int_w = int_oe ? int_out : strap;
   wire         sda_w = !((sda_tx_oe && !sda_tx_out) || sda_low);
   gof_frame_formatter #(.INT_LOW(INT_LOW)) i_gof_frame_formatter (
      .ref_clk(ref_clk), .rst(rst), .ce(ce), .sample_valid(sample_valid),
      .angle_in(angle_in), .rate_in(rate_in), .link_clk(link_clk),
      .strap_int_in(int_w), .int_out(int_out), .int_oe(int_oe),
      .scl_rx_in(scl), .sda_tx_in(sda_w), .sda_tx_out(sda_tx_out), .sda_tx_oe(sda_tx_oe));
   gof_host_model i_gof_host_model (.scl(scl), .sda_low(sda_low), .sda(sda_w));
   ////////////////////////////////////////
   initial
   begin
      ref_clk = 1'b0;
      forever #12.5 ref_clk = ~ref_clk;
   end
   initial
   begin
      link_clk = 1'b0;
      #7;
      forever #40 link_clk = ~link_clk;
   end
   ////////////////////////////////////////
   function automatic logic [31:0] xs(input logic [31:0] s);
      s ^= s << 13;
      s ^= s >> 17;
      s ^= s << 5;
      return s;
   endfunction
   function automatic logic [15:0] wrap(input logic signed [15:0] a);
      logic signed [17:0] t;
      t = a;
      if (t > 18000) t -= 36000;
      else if (t < -18000) t += 36000;
      return t[15:0];
   endfunction
   task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
      num_checks++;
      if (g !== e)
      begin
         $display("[ERR] %s exp %h got %h", n, e, g);
         miscompares++;
      end
   endtask
   task automatic end_of_test;
      $display("checks %0d errors %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   // five cycles: longer than a link period, so the link sees it
   task automatic do_reset(input logic s);
      @(negedge ref_clk);
      rst = 1'b1;
      strap = s;
      repeat (5) @(negedge ref_clk);
      rst = 1'b0;
      repeat (4) @(negedge ref_clk);
      chk("int_oe", 16'h0001, {15'h0, int_oe});
      // idle freeze through the enable
      ce = 1'b0;
      repeat (3) @(negedge ref_clk);
      ce = 1'b1;
      repeat (20) @(negedge ref_clk);
   endtask
   task automatic send(input logic [15:0] a, input logic [15:0] r);
      @(negedge ref_clk);
      sample_valid = 1'b1;
      angle_in = a;
      rate_in = r;
      @(negedge ref_clk);
      sample_valid = 1'b0;
      angle_in = ~a;
      rate_in = ~r;
   endtask
   task automatic wait_int;
      int n;
      n = 0;
      for (int i = 0; i < 400 && int_w !== 1'b0; i++) @(negedge ref_clk);
      while (int_w === 1'b0 && n < 100)
      begin
         n++;
         @(negedge ref_clk);
      end
      chk("int_low", 16'(INT_LOW), 16'(n));
   endtask
   ////////////////////////////////////////
   initial
   begin
      #2_300_000;
      miscompares++;
      end_of_test();
   end
   initial
   begin
      logic [7:0]   d [7];
      logic [8:0]   u;
      logic         ack_n;
      logic [15:0]  a;
      logic [15:0]  r;
      logic [15:0]  w;
      logic [55:0]  x;
      logic [79:0]  y;
      logic [103:0] z;
      logic [7:0]   s;
      miscompares = 0;
      num_checks = 0;
      seed = 32'h09f8ef76;
      rst = 1'b1;
      ce = 1'b1;
      strap = 1'b1;
      sample_valid = 1'b0;
      angle_in = 16'h0000;
      rate_in = 16'h0000;
      do_reset(1'b1);
      i_gof_host_model.i2c_read(7'h6b, ack_n, d);
      chk("nack", 16'h0001, {15'h0, ack_n});
      for (int k = 0; k < 3; k++)
      begin
         seed = xs(seed);
         a = (k == 0) ? 16'h4651 : (k == 1) ? 16'h8000 : seed[15:0];
         r = seed[31:16];
         send(a, r);
         wait_int();
         i_gof_host_model.i2c_read(7'h6a, ack_n, d);
         chk("ack", 16'h0000, {15'h0, ack_n});
         w = wrap(a);
         x = {w, r, 16'(w + r), 8'h00};
         for (int j = 0; j < 7; j++)
            chk("i2c", {8'h00, x[55-8*j -: 8]}, {8'h00, d[j]});
         chk("deg", 16'($signed(w) / 100), 16'($signed({d[0], d[1]}) / 100));
      end
      do_reset(1'b0);
      seed = xs(seed);
      a = seed[15:0];
      r = seed[31:16];
      send(a, r);
      w = wrap(a);
      x[55:40] = 16'hffff + w + r;
      y = {16'hffff, r[7:0], r[15:8], w[7:0], w[15:8], x[47:40], x[55:48], 16'h0000};
      s = 8'h00;
      for (int j = 0; j < 10; j++) s += y[79-8*j -: 8];
      z = {y, s, 8'h0d, 8'h0a};
      for (int j = 0; j < 13; j++)
      begin
         i_gof_host_model.uart_rx(u);
         chk("uart", {8'h00, z[103-8*j -: 8]}, {8'h00, u[7:0]});
         chk("stop", 16'h0001, {15'h0, u[8]});
      end
      end_of_test();
   end
endmodule
